// File: common/pio_irq_pkg.sv
// Constants and carrier types for the interrupt polarity and write protection block
package pio_irq_pkg;
   localparam int LINES = 32;
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;

   // Byte addresses of the registers this block answers
   localparam logic [31:0] ADDR_FALL_LOW_SELECT = 32'h400E0ED0;
   localparam logic [31:0] ADDR_RISE_HIGH_SELECT = 32'h400E0ED4;
   localparam logic [31:0] ADDR_POLARITY_STATUS = 32'h400E0ED8;
   localparam logic [31:0] ADDR_WRITE_PROTECT_MODE = 32'h400E0EE4;
   localparam logic [31:0] ADDR_WRITE_PROTECT_STATUS = 32'h400E0EE8;
   localparam logic [31:0] ADDR_INPUT_HYSTERESIS_CTRL = 32'h400E0F00;

   // Base of the controller; guarded registers are given as offsets from it
   localparam logic [31:0] CTRL_BASE = 32'h400E0E00;
   localparam int GUARDED_COUNT = 16;
   localparam logic [15:0] GUARDED_OFFSET [GUARDED_COUNT] = '{
      16'h0000, 16'h0004,  // Line enable, line disable
      16'h0010, 16'h0014,  // Output enable, output disable
      16'h0020, 16'h0024,  // Input filter enable, disable
      16'h0050, 16'h0054,  // Multi-driver enable, disable
      16'h0060, 16'h0064,  // Pull-up disable, enable
      16'h0070, 16'h0074,  // Peripheral select 1 and 2
      16'h00A0, 16'h00A4,  // Output write enable, disable
      16'h0090, 16'h0098   // Pull-down disable, pull-down status
   };

   // Protect mode register fields
   localparam int PROTECT_ON_BIT = 0;
   localparam int PROTECT_KEY_LSB = 8;
   localparam int PROTECT_KEY_W = 24;
   localparam logic [23:0] KEY_PASSWORD = 24'h50494F;

   // Protect status register fields
   localparam int VIOLATION_FLAG_BIT = 0;
   localparam int VIOLATION_SOURCE_LSB = 8;
   localparam int VIOLATION_SOURCE_W = 16;

   // Reset values
   localparam logic [31:0] POLARITY_RESET = 32'h00000000;
   localparam logic [31:0] HYSTERESIS_RESET = 32'h00000000;
   localparam logic PROTECT_RESET = 1'b0;

   // Per-line detection setup handed to the edge/level detector
   typedef struct packed {
      logic [LINES-1:0] both_edge;
      logic [LINES-1:0] level;
      logic [LINES-1:0] rise_high;
   } irq_cfg_t;

   typedef struct packed {
      logic write;
      logic read;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } bus_req_t;
endpackage

// File: src/pio_irq_polarity_write_protect.sv
// Interrupt polarity select, register write protection and input hysteresis control
`timescale 1ns/1ps

module pio_irq_polarity_write_protect #(
   parameter int LINE_COUNT = pio_irq_pkg::LINES
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [pio_irq_pkg::ADDR_W-1:0] addr,
   input wire logic [pio_irq_pkg::DATA_W-1:0] wdata,
   input wire logic write_strobe,
   input wire logic read_strobe,
   input wire logic [LINE_COUNT-1:0] edge_level_status,
   input wire logic [LINE_COUNT-1:0] extra_irq_mode,
   output logic [pio_irq_pkg::DATA_W-1:0] rdata,
   output pio_irq_pkg::irq_cfg_t irq_cfg,
   output logic [LINE_COUNT-1:0] hysteresis_off,
   output logic protect_active,
   output logic guarded_write_blocked
);
   import pio_irq_pkg::*;

   // Offset of an address from the controller base, low 16 bits
   function automatic logic [15:0] offset_of(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] diff;
      diff = a - CTRL_BASE;
      return diff[15:0];
   endfunction

   // True when the address hits one of the guarded registers
   function automatic logic is_guarded(input logic [ADDR_W-1:0] a);
      logic hit;
      hit = 1'b0;
      if (a[ADDR_W-1:16] == CTRL_BASE[ADDR_W-1:16]) begin
         for (int i = 0; i < GUARDED_COUNT; i++) begin
            if (offset_of(a) == GUARDED_OFFSET[i]) begin
               hit = 1'b1;
            end
         end
      end
      return hit;
   endfunction

   // Registers of this block, as decoded from an address
   typedef enum logic [2:0] {
      UNMAPPED = 3'b000,
      FALL_LOW = 3'b001,
      RISE_HIGH = 3'b010,
      POLARITY = 3'b011,
      PROTECT_MODE = 3'b100,
      PROTECT_STATUS = 3'b101,
      HYSTERESIS = 3'b110
   } reg_sel_t;

   // Shared by the write and the read decode
   function automatic reg_sel_t select_of(input logic [ADDR_W-1:0] a);
      reg_sel_t sel;
      case (a)
         ADDR_FALL_LOW_SELECT: begin
            sel = FALL_LOW;
         end
         ADDR_RISE_HIGH_SELECT: begin
            sel = RISE_HIGH;
         end
         ADDR_POLARITY_STATUS: begin
            sel = POLARITY;
         end
         ADDR_WRITE_PROTECT_MODE: begin
            sel = PROTECT_MODE;
         end
         ADDR_WRITE_PROTECT_STATUS: begin
            sel = PROTECT_STATUS;
         end
         ADDR_INPUT_HYSTERESIS_CTRL: begin
            sel = HYSTERESIS;
         end
         default: begin
            sel = UNMAPPED;
         end
      endcase
      return sel;
   endfunction

   // Bus request as seen this cycle
   bus_req_t req;
   reg_sel_t write_sel;
   reg_sel_t read_sel;

   assign req = '{write: write_strobe, read: read_strobe, addr: addr, wdata: wdata};

   // Decoded only while a strobe is high, so an idle bus selects nothing
   always_comb begin
      write_sel = UNMAPPED;
      if (req.write) begin
         write_sel = select_of(req.addr);
      end
   end

   always_comb begin
      read_sel = UNMAPPED;
      if (req.read) begin
         read_sel = select_of(req.addr);
      end
   end

   // Polarity and hysteresis state
   logic [LINE_COUNT-1:0] polarity;
   logic [LINE_COUNT-1:0] next_polarity;
   logic [LINE_COUNT-1:0] next_hysteresis_off;

   // One polarity bit per line; a zero in a select write leaves its line alone
   for (genvar i = 0; i < LINE_COUNT; i++) begin : g_polarity
      always_comb begin
         next_polarity[i] = polarity[i];
         if (write_sel == FALL_LOW && req.wdata[i]) begin
            next_polarity[i] = 1'b0;
         end
         if (write_sel == RISE_HIGH && req.wdata[i]) begin
            next_polarity[i] = 1'b1;
         end
      end
   end

   // A one turns the input hysteresis of its line off
   always_comb begin
      next_hysteresis_off = hysteresis_off;
      if (write_sel == HYSTERESIS) begin
         next_hysteresis_off = req.wdata[LINE_COUNT-1:0];
      end
   end

   // Reset leaves every line at falling edge or low level
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         polarity <= POLARITY_RESET[LINE_COUNT-1:0];
      end else begin
         polarity <= next_polarity;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         hysteresis_off <= HYSTERESIS_RESET[LINE_COUNT-1:0];
      end else begin
         hysteresis_off <= next_hysteresis_off;
      end
   end

   // Detection setup for the downstream edge/level detector
   irq_cfg_t next_irq_cfg;
   logic [LINE_COUNT-1:0] line_both_edge;
   logic [LINE_COUNT-1:0] line_level;
   logic [LINE_COUNT-1:0] line_rise_high;

   // A line outside the additional mode falls back to both edges, whatever its polarity
   for (genvar i = 0; i < LINE_COUNT; i++) begin : g_detect
      always_comb begin
         line_both_edge[i] = 1'b1;
         line_level[i] = 1'b0;
         line_rise_high[i] = 1'b0;
         if (extra_irq_mode[i]) begin
            line_both_edge[i] = 1'b0;
            line_level[i] = edge_level_status[i];
            line_rise_high[i] = next_polarity[i];
         end
      end
   end

   // Packed for the downstream detector
   always_comb begin
      next_irq_cfg.both_edge = line_both_edge;
      next_irq_cfg.level = line_level;
      next_irq_cfg.rise_high = line_rise_high;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         irq_cfg <= '{both_edge: {LINE_COUNT{1'b1}}, level: '0, rise_high: '0};
      end else begin
         irq_cfg <= next_irq_cfg;
      end
   end

   // Write protection
   logic next_protect_active;
   logic violation_flag;
   logic next_violation_flag;
   logic [VIOLATION_SOURCE_W-1:0] violation_source;
   logic [VIOLATION_SOURCE_W-1:0] next_violation_source;
   logic next_guarded_write_blocked;
   logic violation_now;
   logic status_read;
   logic key_match;

   // The key must match in the same access, otherwise the enable bit is dropped
   always_comb begin
      key_match = req.wdata[PROTECT_KEY_LSB +: PROTECT_KEY_W] == KEY_PASSWORD;
      next_protect_active = protect_active;
      if (write_sel == PROTECT_MODE && key_match) begin
         next_protect_active = req.wdata[PROTECT_ON_BIT];
      end
   end

   // The mode register itself stays writable, so protection can always be lifted
   always_comb begin
      violation_now = 1'b0;
      if (req.write && protect_active) begin
         violation_now = is_guarded(req.addr);
      end
      status_read = read_sel == PROTECT_STATUS;
      next_guarded_write_blocked = violation_now;
   end

   // A violation in the same cycle as the clearing read is kept
   always_comb begin
      next_violation_flag = violation_flag;
      next_violation_source = violation_source;
      if (status_read) begin
         next_violation_flag = 1'b0;
         next_violation_source = '0;
      end
      if (violation_now) begin
         next_violation_flag = 1'b1;
         next_violation_source = offset_of(req.addr);
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         protect_active <= PROTECT_RESET;
         guarded_write_blocked <= 1'b0;
      end else begin
         protect_active <= next_protect_active;
         guarded_write_blocked <= next_guarded_write_blocked;
      end
   end

   // Flag and source are always cleared together
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         violation_flag <= 1'b0;
         violation_source <= '0;
      end else begin
         violation_flag <= next_violation_flag;
         violation_source <= next_violation_source;
      end
   end

   // Read data, valid in the cycle after the read strobe only
   logic [DATA_W-1:0] next_rdata;

   always_comb begin
      next_rdata = '0;
      if (req.read) begin
         case (read_sel)
            POLARITY: begin
               next_rdata[LINE_COUNT-1:0] = polarity;
            end
            PROTECT_MODE: begin
               // The key field is never returned
               next_rdata[PROTECT_ON_BIT] = protect_active;
            end
            PROTECT_STATUS: begin
               next_rdata[VIOLATION_FLAG_BIT] = violation_flag;
               next_rdata[VIOLATION_SOURCE_LSB +: VIOLATION_SOURCE_W] = violation_source;
            end
            HYSTERESIS: begin
               next_rdata[LINE_COUNT-1:0] = hysteresis_off;
            end
            // Write-only and unmapped addresses read as zero
            default: begin
               next_rdata = '0;
            end
         endcase
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rdata <= '0;
      end else begin
         rdata <= next_rdata;
      end
   end
endmodule // pio_irq_polarity_write_protect

// File: testbench/pio_irq_props.sv
// Checker for polarity, write protection and hysteresis outputs
`timescale 1ns/1ps
module pio_irq_props
   import pio_irq_pkg::*;
#(
   parameter int LINE_COUNT = LINES
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [31:0] addr,
   input wire logic [31:0] wdata,
   input wire logic write_strobe,
   input wire logic read_strobe,
   input wire logic [LINE_COUNT-1:0] edge_level_status,
   input wire logic [LINE_COUNT-1:0] extra_irq_mode,
   input wire logic [31:0] rdata,
   input wire pio_irq_pkg::irq_cfg_t irq_cfg,
   input wire logic [LINE_COUNT-1:0] hysteresis_off,
   input wire logic protect_active,
   input wire logic guarded_write_blocked
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   logic guarded;
   logic mode_wr;
   logic key_ok;
   assign mode_wr = write_strobe && addr == ADDR_WRITE_PROTECT_MODE;
   assign key_ok = wdata[31:8] == KEY_PASSWORD;
   // Decode of the guarded addresses
   always_comb begin
      guarded = 1'b0;
      for (int i = 0; i < GUARDED_COUNT; i++)
         if (addr == CTRL_BASE + 32'(GUARDED_OFFSET[i])) guarded = 1'b1;
   end
   AST_FALL_CLEARS: assert property (write_strobe && addr == ADDR_FALL_LOW_SELECT |=>
      (irq_cfg.rise_high & $past(wdata)) == '0) else $error("fall select left a line rising");
   AST_RISE_SETS: assert property (write_strobe && addr == ADDR_RISE_HIGH_SELECT |=>
      (irq_cfg.rise_high & $past(wdata)) == ($past(wdata) & $past(extra_irq_mode))) else $error("rise select lost");
   AST_LEVEL_SEL: assert property (##1 1 |->
      irq_cfg.level == ($past(edge_level_status) & $past(extra_irq_mode))) else $error("level select wrong");
   AST_BOTH_EDGE: assert property (##1 1 |-> irq_cfg.both_edge == ~$past(extra_irq_mode))
      else $error("both edge select wrong");
   AST_PROTECT_ON: assert property (mode_wr && key_ok && wdata[0] |=> protect_active)
      else $error("protection not enabled");
   AST_PROTECT_OFF: assert property (mode_wr && key_ok && !wdata[0] |=> !protect_active)
      else $error("protection not disabled");
   AST_BAD_KEY: assert property (mode_wr && !key_ok |=> $stable(protect_active))
      else $error("wrong key changed protection");
   AST_KEY_READ: assert property (read_strobe && addr == ADDR_WRITE_PROTECT_MODE |=>
      rdata == {31'h0, protect_active}) else $error("protect mode readback wrong");
   AST_BLOCKED: assert property (write_strobe && guarded && protect_active |=> guarded_write_blocked)
      else $error("guarded write not reported");
   AST_NOT_BLOCKED: assert property (!(write_strobe && guarded && protect_active) |=> !guarded_write_blocked)
      else $error("spurious violation");
   AST_HYST: assert property (write_strobe && addr == ADDR_INPUT_HYSTERESIS_CTRL |=>
      hysteresis_off == $past(wdata)) else $error("hysteresis control not taken");
   AST_RDATA_IDLE: assert property (!read_strobe |=> rdata == '0)
      else $error("read data outside its cycle");
endmodule // pio_irq_props
bind pio_irq_polarity_write_protect pio_irq_props #(.LINE_COUNT(LINE_COUNT)) i_pio_irq_props (.clock(clock),
   .rst(rst), .addr(addr), .wdata(wdata), .write_strobe(write_strobe), .read_strobe(read_strobe),
   .edge_level_status(edge_level_status), .extra_irq_mode(extra_irq_mode), .rdata(rdata), .irq_cfg(irq_cfg),
   .hysteresis_off(hysteresis_off), .protect_active(protect_active), .guarded_write_blocked(guarded_write_blocked));

// File: testbench/tb_top.sv
// Self-checking bench for the polarity, write protection and hysteresis block
`timescale 1ns/1ps
module tb_top;
   import pio_irq_pkg::*;
   logic clock = 0, rst = 1, write_strobe = 0, read_strobe = 0, protect_active, guarded_write_blocked;
   logic [31:0] addr = '0, wdata = '0, edge_level_status = '0, extra_irq_mode = '0, rdata, hysteresis_off;
   irq_cfg_t irq_cfg;
   int error_cnt = 0, n_checks = 0;
   pio_irq_polarity_write_protect i_pio_irq_polarity_write_protect (.clock(clock), .rst(rst), .addr(addr),
      .wdata(wdata), .write_strobe(write_strobe), .read_strobe(read_strobe), .edge_level_status(edge_level_status),
      .extra_irq_mode(extra_irq_mode), .rdata(rdata), .irq_cfg(irq_cfg), .hysteresis_off(hysteresis_off),
      .protect_active(protect_active), .guarded_write_blocked(guarded_write_blocked));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] v);
      @(posedge clock);
      write_strobe <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clock);
      write_strobe <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] exp);
      @(posedge clock);
      read_strobe <= 1'b1;
      addr <= a;
      @(posedge clock);
      read_strobe <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask
   task automatic t_polarity;
      chk(irq_cfg.both_edge, '1);
      rd(ADDR_POLARITY_STATUS, 32'h0);
      @(posedge clock);
      extra_irq_mode <= '1;
      edge_level_status <= 32'h0F0F0F0F;
      wr(ADDR_RISE_HIGH_SELECT, 32'hA5A5A5A5);
      rd(ADDR_POLARITY_STATUS, 32'hA5A5A5A5);
      wr(ADDR_FALL_LOW_SELECT, 32'h0000FFFF);
      wr(ADDR_RISE_HIGH_SELECT, 32'h0);
      rd(ADDR_POLARITY_STATUS, 32'hA5A50000);
      chk(irq_cfg.rise_high, 32'hA5A50000);
      chk(irq_cfg.level, 32'h0F0F0F0F);
      @(posedge clock);
      extra_irq_mode <= 32'hFF00FF00;
      @(posedge clock);
      #1;
      chk(irq_cfg.both_edge, 32'h00FF00FF);
      chk(irq_cfg.level, 32'h0F000F00);
      chk(irq_cfg.rise_high, 32'hA5000000);
      $display("test polarity done");
   endtask
   task automatic t_protect;
      wr(ADDR_WRITE_PROTECT_MODE, 32'h50494E01);
      chk(protect_active, 0);
      wr(ADDR_WRITE_PROTECT_MODE, {KEY_PASSWORD, 8'h01});
      chk(protect_active, 1);
      rd(ADDR_WRITE_PROTECT_MODE, 32'h1);
      wr(ADDR_WRITE_PROTECT_MODE, 32'h00000000);
      chk(protect_active, 1);
      for (int i = 0; i < GUARDED_COUNT; i++) begin
         wr(CTRL_BASE + 32'(GUARDED_OFFSET[i]), '1);
         chk(guarded_write_blocked, 1);
         rd(ADDR_WRITE_PROTECT_STATUS, {8'h0, GUARDED_OFFSET[i], 8'h01});
         rd(ADDR_WRITE_PROTECT_STATUS, 32'h0);
      end
      wr(CTRL_BASE + 32'h08, '1);
      chk(guarded_write_blocked, 0);
      rd(ADDR_WRITE_PROTECT_STATUS, 32'h0);
      wr(ADDR_WRITE_PROTECT_MODE, {KEY_PASSWORD, 8'h00});
      chk(protect_active, 0);
      wr(CTRL_BASE + 32'h10, '1);
      chk(guarded_write_blocked, 0);
      $display("test protect done");
   endtask
   task automatic t_hyst;
      rd(ADDR_INPUT_HYSTERESIS_CTRL, 32'h0);
      wr(ADDR_INPUT_HYSTERESIS_CTRL, 32'h80000001);
      rd(ADDR_INPUT_HYSTERESIS_CTRL, 32'h80000001);
      chk(hysteresis_off, 32'h80000001);
      rd(ADDR_RISE_HIGH_SELECT, 32'h0);
      rd(CTRL_BASE + 32'h200, 32'h0);
      $display("test hysteresis done");
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial forever #12.5 clock = ~clock;
   initial begin
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      t_polarity();
      t_protect();
      t_hyst();
      complete_run();
   end
   initial begin
      repeat (20000) @(posedge clock);
      error_cnt++;
      complete_run();
   end
endmodule // tb_top
